/* hw/adc_serial_command_port.sv */
/*
  Serial command port of a sigma-delta converter: command decode, register
  shifting, continuous read and lost-sync recovery.
  Assumes sclk idles high and belongs to the host; the core runs on clk_sys.
*/
`timescale 1ns/1ps
module adc_serial_command_port #(
  parameter logic [7:0] ID_VALUE = 8'h5a // Arbitrary identity value
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout_rdy_n,
  input wire logic conv_done,
  input wire logic conv_soon,
  input wire adc_port_pkg::conv_s conv_res,
  output adc_port_pkg::cfg_s cfg,
  output logic part_reset
);
  import adc_port_pkg::*;

  // ----------------------------------------------------------------
  // Link-side state (sclk)
  // ----------------------------------------------------------------
  port_state_e state_r;
  logic [5:0] ones_r, cnt_r, len_r;
  logic [6:0] cmd_r;
  logic [31:0] sh_r;
  logic [7:0] win_r;
  logic busy_r, taken_r, rdy_s1_r, rdy_s2_r;
  logic [2:0] tgl_r;
  cfg_s cfg_l_r;
  logic drive_r, dout_r, new_s1_r, new_s2_r, seen_r;
  // System-side state
  logic ready_n_r;
  conv_s res_r;
  logic [2:0] t1_r, t2_r, t3_r;
  logic new_tgl_r;

  logic act, lost, last, last_cmd;
  logic [6:0] cmd_nxt;
  logic [7:0] win_nxt, stat_byte;
  logic [2:0] sel_nxt, ev;
  logic [31:0] rd_word, data_word;
  logic [5:0] rd_len, data_len;
  logic [23:0] wr_val;
  logic to_stream, stream_start, wr_done, rd_data_done;
  logic fresh, shifting;

  assign act = ~cs_n;
  assign lost = act & din & (ones_r == ONES_LIMIT - 6'd1);
  assign last = (cnt_r == len_r - 6'd1);
  assign last_cmd = (cnt_r == CMD_TAIL_BITS - 6'd1);
  assign cmd_nxt = {cmd_r[5:0], din};
  assign sel_nxt = cmd_nxt[SEL_HI:SEL_LO];
  assign win_nxt = {win_r[6:0], din};
  assign wr_val = {sh_r[22:0], din};
  // Result word is read while ready is low; the core only replaces it
  // after pulling ready high, so it is quiet whenever it is sampled.
  assign stat_byte = {rdy_s2_r, res_r.err, res_r.noref, res_r.parity, 1'b0, res_r.chan};
  assign data_word = cfg_l_r.mode[DATSTA_POS] ? {res_r.data, stat_byte}
                                              : {res_r.data, 8'h00};
  assign data_len = cfg_l_r.mode[DATSTA_POS] ? LEN_DSTAT : LEN_WORD;
  // Bits 1 and 0 are not decoded.
  assign to_stream = cmd_nxt[STREAM_POS] & (sel_nxt == SEL_DATA);
  // New results arrive as a toggle: sclk may stop while ready is low,
  // and the synchronised level alone would miss the high pulse between results.
  assign fresh = new_s2_r ^ seen_r;
  assign stream_start = !busy_r & !rdy_s2_r & (!taken_r | fresh);
  assign wr_done = act & !lost & (state_r == ST_WR) & last;
  assign rd_data_done = act & !lost & last &
                        ((state_r == ST_RD & cmd_r[SEL_HI:SEL_LO] == SEL_DATA) |
                         (state_r == ST_STREAM & busy_r & win_nxt != CMD_STREAM_OFF));

  // ----------------------------------------------------------------
  // Register select map
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = {cfg_l_r.mode, 8'h00};
    rd_len = LEN_WORD;
    case (sel_nxt)
      SEL_STAT: begin
        rd_word = {stat_byte, 24'h000000};
        rd_len = LEN_BYTE;
      end
      SEL_MODE: rd_word = {cfg_l_r.mode, 8'h00};
      SEL_CONF: rd_word = {cfg_l_r.conf, 8'h00};
      SEL_DATA: begin
        rd_word = data_word;
        rd_len = data_len;
      end
      SEL_ID: begin
        rd_word = {ID_VALUE, 24'h000000};
        rd_len = LEN_BYTE;
      end
      SEL_GPO: begin
        rd_word = {cfg_l_r.gpo, 24'h000000};
        rd_len = LEN_BYTE;
      end
      SEL_OFFS: rd_word = {cfg_l_r.offs, 8'h00};
      SEL_FS: rd_word = {cfg_l_r.fs, 8'h00};
      default: rd_word = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Lost-sync counter
  // ----------------------------------------------------------------
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      ones_r <= 6'd0;
    end else if (act) begin
      if (!din) begin
        ones_r <= 6'd0;
      end else if (ones_r != ONES_LIMIT) begin
        ones_r <= ones_r + 6'd1; // Saturates so one long run resets once
      end
    end
  end

  // ----------------------------------------------------------------
  // Command / transfer sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_WAIT;
      cnt_r <= 6'd0;
      cmd_r <= 7'h00;
      sh_r <= 32'h00000000;
      len_r <= LEN_BYTE;
      busy_r <= 1'b0;
    end else if (lost) begin
      state_r <= ST_WAIT;
      cnt_r <= 6'd0;
      cmd_r <= 7'h00;
      busy_r <= 1'b0;
    end else if (act) begin
      case (state_r)
        ST_WAIT: begin
          if (!din) begin
            state_r <= ST_CMD;
            cnt_r <= 6'd0;
          end
        end
        ST_CMD: begin
          cmd_r <= cmd_nxt;
          cnt_r <= cnt_r + 6'd1;
          if (last_cmd) begin
            cnt_r <= 6'd0;
            len_r <= rd_len;
            busy_r <= 1'b0;
            sh_r <= rd_word;
            if (cmd_nxt[RW_POS]) begin
              state_r <= to_stream ? ST_STREAM : ST_RD;
            end else if (sel_nxt == SEL_STAT) begin
              state_r <= ST_WAIT;
            end else begin
              state_r <= ST_WR;
            end
          end
        end
        ST_RD: begin
          sh_r <= sh_r << 1;
          cnt_r <= cnt_r + 6'd1;
          if (last) begin
            state_r <= ST_WAIT;
          end
        end
        ST_WR: begin
          sh_r <= {sh_r[30:0], din};
          cnt_r <= cnt_r + 6'd1;
          if (last) begin
            state_r <= ST_WAIT;
          end
        end
        ST_STREAM: begin
          if (win_nxt == CMD_STREAM_OFF) begin
            state_r <= ST_WAIT;
            busy_r <= 1'b0;
          end else if (busy_r) begin
            sh_r <= sh_r << 1;
            cnt_r <= cnt_r + 6'd1;
            busy_r <= !last;
          end else if (stream_start) begin
            sh_r <= data_word << 1;
            len_r <= data_len;
            cnt_r <= 6'd1;
            busy_r <= 1'b1;
          end
        end
        default: state_r <= ST_WAIT;
      endcase
    end
  end

  // Exit detection slides over din; a low-held din never matches.
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      win_r <= 8'hff;
      taken_r <= 1'b0;
    end else if (act) begin
      win_r <= (state_r == ST_STREAM) ? win_nxt : 8'hff;
      if (rd_data_done) begin
        taken_r <= 1'b1;
      end else if (rdy_s2_r | fresh | state_r != ST_STREAM) begin
        taken_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link-side register copy and event toggles
  // ----------------------------------------------------------------
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      cfg_l_r <= {MODE_RST, WORD_RST, GPO_RST, WORD_RST, WORD_RST};
    end else if (lost) begin
      cfg_l_r <= {MODE_RST, WORD_RST, GPO_RST, WORD_RST, WORD_RST};
    end else if (wr_done) begin
      case (cmd_r[SEL_HI:SEL_LO])
        SEL_MODE: cfg_l_r.mode <= wr_val;
        SEL_CONF: cfg_l_r.conf <= wr_val;
        SEL_GPO: cfg_l_r.gpo <= wr_val[7:0];
        SEL_OFFS: cfg_l_r.offs <= wr_val;
        SEL_FS: cfg_l_r.fs <= wr_val;
        default: cfg_l_r <= cfg_l_r; // Read-only targets drop the word
      endcase
    end
  end

  // Bit 0 write done, bit 1 data read done, bit 2 lost sync
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      tgl_r <= 3'b000;
    end else begin
      tgl_r <= tgl_r ^ {lost, rd_data_done, wr_done};
    end
  end

  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      rdy_s1_r <= 1'b1;
      rdy_s2_r <= 1'b1;
      new_s1_r <= 1'b0;
      new_s2_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      rdy_s1_r <= ready_n_r;
      rdy_s2_r <= rdy_s1_r;
      new_s1_r <= new_tgl_r;
      new_s2_r <= new_s1_r;
      seen_r <= new_s2_r;
    end
  end

  // Output bits launch on the falling edge for rising-edge capture
  always_ff @(negedge sclk or negedge resetn) begin
    if (!resetn) begin
      drive_r <= 1'b0;
      dout_r <= 1'b1;
    end else begin
      drive_r <= shifting;
      dout_r <= (state_r == ST_STREAM & !busy_r) ? data_word[31] : sh_r[31];
    end
  end

  // Pin shows shifted data while driving, otherwise the ready flag; the
  // mux is the one unregistered path, kept to share the pin.
  // Gated by live state so the flag returns as soon as a transfer ends
  // or cs_n rises, even when sclk then stays high.
  assign shifting = act & ((state_r == ST_RD) |
                    ((state_r == ST_STREAM) & (busy_r | stream_start)));
  assign dout_rdy_n = (drive_r & shifting) ? dout_r : ready_n_r;

  // ----------------------------------------------------------------
  // System side
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      t1_r <= 3'b000;
      t2_r <= 3'b000;
      t3_r <= 3'b000;
    end else begin
      t1_r <= tgl_r;
      t2_r <= t1_r;
      t3_r <= t2_r;
    end
  end
  assign ev = t2_r ^ t3_r;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      new_tgl_r <= 1'b0;
    end else if (conv_done & !ev[2]) begin
      new_tgl_r <= ~new_tgl_r;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ready_n_r <= 1'b1;
      res_r <= '0;
    end else if (ev[2]) begin
      ready_n_r <= 1'b1;
      res_r <= '0;
    end else if (conv_done) begin
      ready_n_r <= 1'b0;
      res_r <= conv_res;
    end else if (conv_soon | ev[1]) begin
      ready_n_r <= 1'b1;
    end
  end

  // Link copy is stable for many sclk cycles after each event
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg <= {MODE_RST, WORD_RST, GPO_RST, WORD_RST, WORD_RST};
      part_reset <= 1'b0;
    end else begin
      part_reset <= ev[2];
      if (ev[0] | ev[2]) begin
        cfg <= cfg_l_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_gate_hold;
    @(posedge sclk) disable iff (!resetn)
      (state_r == ST_WAIT && act && din && !lost) |=> state_r == ST_WAIT;
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gate bit advanced");
  property p_gate_open;
    @(posedge sclk) disable iff (!resetn)
      (state_r == ST_WAIT && act && !din && !lost) |=> state_r == ST_CMD && cnt_r == 6'd0;
  endproperty
  a_gate_open: assert property (p_gate_open) else $error("gate zero ignored");
  property p_lost;
    @(posedge sclk) disable iff (!resetn)
      lost |=> state_r == ST_WAIT && cfg_l_r.mode == MODE_RST;
  endproperty
  a_lost: assert property (p_lost) else $error("forty ones did not reset");
  property p_part_reset;
    @(posedge clk_sys) disable iff (!resetn)
      $rose(part_reset) |=> !part_reset && ready_n_r;
  endproperty
  a_part_reset: assert property (p_part_reset) else $error("part reset not one pulse");
  property p_read_dir;
    @(posedge sclk) disable iff (!resetn)
      (state_r == ST_CMD && act && !lost && last_cmd && cmd_nxt[RW_POS] && !to_stream)
        |=> state_r == ST_RD;
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("read not entered");
  property p_read_len;
    @(posedge sclk) disable iff (!resetn)
      (state_r == ST_CMD && act && !lost && last_cmd && cmd_nxt[RW_POS] &&
       sel_nxt == SEL_ID) |=> len_r == LEN_BYTE;
  endproperty
  a_read_len: assert property (p_read_len) else $error("wrong read width");
  property p_read_end;
    @(posedge sclk) disable iff (!resetn)
      (state_r == ST_RD && act && !lost && last) |=> state_r == ST_WAIT;
  endproperty
  a_read_end: assert property (p_read_end) else $error("read did not finish");
  property p_mode_wr;
    @(posedge sclk) disable iff (!resetn)
      (wr_done && cmd_r[SEL_HI:SEL_LO] == SEL_MODE) |=> cfg_l_r.mode == $past(wr_val);
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode write lost");
  property p_stream_exit;
    @(posedge sclk) disable iff (!resetn)
      (state_r == ST_STREAM && act && !lost && win_nxt == CMD_STREAM_OFF)
        |=> state_r == ST_WAIT;
  endproperty
  a_stream_exit: assert property (p_stream_exit) else $error("stream exit missed");
  property p_ready;
    @(posedge clk_sys) disable iff (!resetn)
      (conv_done && !ev[2]) |=> !ready_n_r;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not shown");

endmodule // adc_serial_command_port

/* hw/adc_port_pkg.sv */
/*
  Constants, field layout and carrier types of the serial command port.
  Assumes a 24-bit converter core on the system clock behind the port.
*/
package adc_port_pkg;
  // ----------------------------------------------------------------
  // Command byte layout, data-status mode bit and lost-sync limit
  // ----------------------------------------------------------------
  localparam logic [5:0] CMD_TAIL_BITS = 6'd7;
  localparam int RW_POS = 6;
  localparam int SEL_HI = 5;
  localparam int SEL_LO = 3;
  localparam int STREAM_POS = 2;
  localparam int DATSTA_POS = 20;
  localparam logic [7:0] CMD_STREAM_OFF = 8'h58;
  localparam logic [5:0] ONES_LIMIT = 6'd40;
  // ----------------------------------------------------------------
  // Register select codes, lengths and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_STAT = 3'h0;
  localparam logic [2:0] SEL_MODE = 3'h1;
  localparam logic [2:0] SEL_CONF = 3'h2;
  localparam logic [2:0] SEL_DATA = 3'h3;
  localparam logic [2:0] SEL_ID = 3'h4;
  localparam logic [2:0] SEL_GPO = 3'h5;
  localparam logic [2:0] SEL_OFFS = 3'h6;
  localparam logic [2:0] SEL_FS = 3'h7;
  localparam logic [5:0] LEN_BYTE = 6'h08;
  localparam logic [5:0] LEN_WORD = 6'h18;
  localparam logic [5:0] LEN_DSTAT = 6'h20;
  localparam logic [23:0] MODE_RST = 24'h080060;
  localparam logic [23:0] WORD_RST = 24'h000000;
  localparam logic [7:0] GPO_RST = 8'h00;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_WAIT = 5'b00001,
    ST_CMD = 5'b00010,
    ST_WR = 5'b00100,
    ST_RD = 5'b01000,
    ST_STREAM = 5'b10000
  } port_state_e;
  typedef struct packed {
    logic [23:0] mode;
    logic [23:0] conf;
    logic [7:0] gpo;
    logic [23:0] offs;
    logic [23:0] fs;
  } cfg_s;
  typedef struct packed {
    logic [23:0] data;
    logic err;
    logic noref;
    logic parity;
    logic [2:0] chan;
  } conv_s;
endpackage

/* test/host_model.sv */
/*
  Host serial master for the command port: drives sclk, cs_n and din.
  Assumes the device launches dout on sclk falls; sclk stands high between frames.
*/
`timescale 1ns/1ps
module host_model (
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  logic [31:0] rd_word;
  event got;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b1;
    rd_word = '0;
  end
  // ----------------------------------------------------------------
  // Bit transfer
  // ----------------------------------------------------------------
  // Odd start offset keeps sclk out of step with clk_sys
  task automatic bits(input logic [31:0] val, input int n, input bit rep);
    logic [31:0] rd;
    rd = '0;
    #1.3;
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      din = val[i];
      #6;
      sclk = 1'b1;
      rd = {rd[30:0], dout};
      #6;
    end
    if (rep) begin
      rd_word = rd;
      -> got;
    end
  endtask
  // Idle high so stray clocks stay behind the gate bit
  task automatic idle();
    #6;
    cs_n = 1'b1;
    din = 1'b1;
  endtask
endmodule // host_model

/* test/tb.sv */
/*
  Self-checking bench for the serial command port.
  Assumes host_model drives the link; conversions are pulsed here on clk_sys.
*/
`timescale 1ns/1ps
module tb;
  import adc_port_pkg::*;
  localparam logic [7:0] ID_V = 8'h3c; // Arbitrary identity value
  localparam logic [2:0] SELS [4] = '{SEL_CONF, SEL_GPO, SEL_OFFS, SEL_FS};
  localparam int LENS [4] = '{24, 8, 24, 24};
  logic clk_sys, resetn, sclk, cs_n, din, dout_rdy_n, conv_done, conv_soon, part_reset;
  conv_s conv_res;
  cfg_s cfg;
  conv_s r;
  logic [23:0] w;
  logic [31:0] exp_q[$];
  int num_errors = 0;
  int total_checks = 0;
  int resets = 0;
  int seed = 95;

  adc_serial_command_port #(.ID_VALUE(ID_V)) dut (.clk_sys(clk_sys), .resetn(resetn),
    .sclk(sclk), .cs_n(cs_n), .din(din), .dout_rdy_n(dout_rdy_n), .conv_done(conv_done),
    .conv_soon(conv_soon), .conv_res(conv_res), .cfg(cfg), .part_reset(part_reset));
  host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_rdy_n));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (part_reset === 1'b1) resets++;
  end
  // ----------------------------------------------------------------
  // Checking and reporting
  // ----------------------------------------------------------------
  task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  always @(host.got) begin
    check32("read word", exp_q.pop_front(), host.rd_word);
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
  // ----------------------------------------------------------------
  // Stimulus helpers
  // ----------------------------------------------------------------
  task automatic access(input logic [7:0] cmd, input int n, input logic [31:0] v);
    host.bits({24'h0, cmd}, 8, 1'b0);
    host.bits(v, n, cmd[6]);
    host.idle();
  endtask
  task automatic rd(input logic [2:0] sel, input int n, input logic [31:0] exp);
    exp_q.push_back(exp);
    access({2'b01, sel, 3'b000}, n, 32'h0);
  endtask
  task automatic convert();
    @(posedge clk_sys);
    r = conv_s'(30'($random(seed)));
    conv_res <= r;
    conv_done <= 1'b1;
    @(posedge clk_sys);
    conv_done <= 1'b0;
  endtask
  // Bounded wait for the ready level while the pin is not shifting
  task automatic wait_rdy(input logic lvl);
    int k;
    k = 0;
    while (dout_rdy_n !== lvl && k < 200) begin
      @(negedge clk_sys);
      k++;
    end
    check32("ready level", {31'h0, lvl}, {31'h0, dout_rdy_n});
  endtask
  function automatic logic [23:0] fld(input logic [2:0] s);
    case (s)
      SEL_CONF: fld = cfg.conf;
      SEL_GPO: fld = {16'h0, cfg.gpo};
      SEL_OFFS: fld = cfg.offs;
      default: fld = cfg.fs;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    conv_done = 1'b0;
    conv_soon = 1'b0;
    conv_res = '0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check32("mode", {8'h0, MODE_RST}, {8'h0, cfg.mode});
    check32("ready", 32'h1, {31'h0, dout_rdy_n});
    rd(SEL_STAT, 8, 32'h80);
    $display("reset test done");
    host.bits(32'hffffffff, 5, 1'b0);
    w = 24'($random(seed)) & 24'h0cbfff;
    access({2'b00, SEL_MODE, 3'b000}, 24, {8'h0, w});
    repeat (8) @(posedge clk_sys);
    check32("mode write", {8'h0, w}, {8'h0, cfg.mode});
    rd(SEL_MODE, 24, {8'h0, w});
    for (int i = 0; i < 4; i++) begin
      w = 24'($random(seed));
      if (LENS[i] == 8) w[23:8] = '0;
      access({2'b00, SELS[i], 3'b000}, LENS[i], {8'h0, w});
      repeat (8) @(posedge clk_sys);
      check32("cfg field", {8'h0, w}, {8'h0, fld(SELS[i])});
      rd(SELS[i], LENS[i], {8'h0, w});
    end
    host.bits(32'h0, 8, 1'b0);
    rd(SEL_ID, 8, {24'h0, ID_V});
    $display("register test done");
    convert();
    wait_rdy(1'b0);
    rd(SEL_STAT, 8, {24'h0, 1'b0, r.err, r.noref, r.parity, 1'b0, r.chan});
    rd(SEL_DATA, 24, {8'h0, r.data});
    wait_rdy(1'b1);
    convert();
    wait_rdy(1'b0);
    @(posedge clk_sys);
    conv_soon <= 1'b1;
    @(posedge clk_sys);
    conv_soon <= 1'b0;
    wait_rdy(1'b1);
    access({2'b00, SEL_MODE, 3'b000}, 24, {8'h0, MODE_RST | (24'h1 << DATSTA_POS)});
    convert();
    wait_rdy(1'b0);
    rd(SEL_DATA, 32, {r.data, 1'b0, r.err, r.noref, r.parity, 1'b0, r.chan});
    access({2'b00, SEL_MODE, 3'b000}, 24, {8'h0, MODE_RST});
    $display("conversion test done");
    host.bits(32'h5c, 8, 1'b0);
    repeat (2) begin
      convert();
      exp_q.push_back({8'h0, r.data});
      wait_rdy(1'b0);
      // Two leading clocks carry ready and the result toggle into sclk
      host.bits(32'h0, 26, 1'b1);
      wait_rdy(1'b1);
    end
    convert();
    wait_rdy(1'b0);
    host.bits({24'h0, CMD_STREAM_OFF}, 8, 1'b0);
    host.idle();
    rd(SEL_ID, 8, {24'h0, ID_V});
    $display("stream test done");
    host.bits(32'hffffffff, 32, 1'b0);
    host.bits(32'hffffffff, 7, 1'b0);
    rd(SEL_ID, 8, {24'h0, ID_V});
    repeat (20) @(posedge clk_sys);
    check32("reset pulses", 32'h0, resets);
    host.bits(32'h5c, 8, 1'b0);
    host.bits(32'hffffffff, 32, 1'b0);
    host.bits(32'hffffffff, 8, 1'b0);
    host.idle();
    repeat (20) @(posedge clk_sys);
    check32("reset pulses", 32'h1, resets);
    check32("conf after reset", 32'h0, {8'h0, cfg.conf});
    check32("gpo after reset", 32'h0, {24'h0, cfg.gpo});
    rd(SEL_STAT, 8, 32'h80);
    $display("lost sync test done");
    check32("pending reads", 32'h0, exp_q.size());
    report_and_stop();
  end
endmodule // tb
